// ==== mra_regs.svh ====
// register offsets, field positions and page constants of the metering register access block
`ifndef MRA_REGS_SVH
`define MRA_REGS_SVH

// ==========================================================
// direct registers
`define MRA_OFS_PTR 8'h91
`define MRA_OFS_DAT_LO 8'h92
`define MRA_OFS_DAT_MID 8'h93
`define MRA_OFS_DAT_HI 8'h94
`define MRA_OFS_VRMS_LO 8'hD1
`define MRA_OFS_VRMS_MID 8'hD2
`define MRA_OFS_VRMS_HI 8'hD3
`define MRA_OFS_IRMS_LO 8'hD4
`define MRA_OFS_IRMS_MID 8'hD5
`define MRA_OFS_IRMS_HI 8'hD6
`define MRA_OFS_IEN_LO 8'hD9
`define MRA_OFS_IEN_MID 8'hDA
`define MRA_OFS_IEN_HI 8'hDB
`define MRA_OFS_IST_LO 8'hDC
`define MRA_OFS_IST_MID 8'hDD
`define MRA_OFS_IST_HI 8'hDE
`define MRA_OFS_WAV1_LO 8'hE2
`define MRA_OFS_WAV1_MID 8'hE3
`define MRA_OFS_WAV1_HI 8'hE4
`define MRA_OFS_WAV2_LO 8'hE5
`define MRA_OFS_WAV2_MID 8'hE6
`define MRA_OFS_WAV2_HI 8'hE7

// ==========================================================
// pointer fields and reset values
`define MRA_PTR_DIR_BIT 7
`define MRA_PTR_ADDR_MSB 6
`define MRA_RST_BYTE 8'h00
`define MRA_RST_WORD 24'h000000

// ==========================================================
// one-byte registers of the internal page
`define MRA_PG_BYTE_FIRST 7'h0B
`define MRA_PG_BYTE_LAST 7'h10
`define MRA_PG_BYTE_SINGLE 7'h13

`endif

// ==== mra_pkg.sv ====
// types shared by the metering register access block
`include "mra_regs.svh"

package mra_pkg;

	// ==========================================================
	// transfer sequencer states
	typedef enum logic [2:0]
	{
		MRA_IDLE = 3'b001,
		MRA_REQ = 3'b010,
		MRA_DRAIN = 3'b100
	} mra_state_t;

	// ==========================================================
	// one pointer transfer towards the internal page
	typedef struct packed
	{
		logic write;
		logic [6:0] addr;
		logic [23:0] data;
	} mra_page_req_t;

	// tells whether an internal page address holds a single byte
	function automatic logic mra_is_byte_reg(input logic [6:0] addr);
		mra_is_byte_reg = ((addr >= `MRA_PG_BYTE_FIRST) && (addr <= `MRA_PG_BYTE_LAST))
			|| (addr == `MRA_PG_BYTE_SINGLE);
	endfunction : mra_is_byte_reg

endpackage : mra_pkg

// ==== mra_top.sv ====
// metering register access: direct metering registers, pointer window and page handshake
`timescale 1ns/1ps
`include "mra_regs.svh"

// Operation
// - pointer bit 7 selects write (1) or read (0); bits 6:0 give page address.
// - pointer write with direction set copies the three data bytes to the page.
// - one-byte page register writes take only the low data byte.
// - pointer write with direction clear loads the page register into the data bytes.
// - one-byte page register reads fill the low byte and zero the middle and high.
// - each interrupt status byte latches the live interrupt state when that byte is read.
// - reading a high byte captures all 24 bits of that rms or waveform value.
// - low or middle byte reads without the high byte return the previous capture.
// - pointer at 0x91; data bytes low, middle, high at 0x92 to 0x94.
// - interrupt enables at 0xD9-0xDB and statuses at 0xDC-0xDE, readable and writable.
// - two waveform samples read-only at 0xE2-0xE4 and 0xE5-0xE7.
// - every pointer read is its own strobe so read-with-clear aliases clear once.
module mra_top
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	input wire logic [23:0] VRMS_IN,
	input wire logic [23:0] IRMS_IN,
	input wire logic [23:0] WAV1_IN,
	input wire logic [23:0] WAV2_IN,
	input wire logic [23:0] IRQ_STATE_IN,
	output logic [23:0] IRQ_ENABLE,
	output logic [23:0] IRQ_CLEAR,
	output mra_pkg::mra_page_req_t PAGE_REQ,
	output logic PAGE_STROBE,
	input wire logic PAGE_ACK,
	input wire logic [23:0] PAGE_RDATA,
	output logic XFER_BUSY
);
	import mra_pkg::*;

	// ==========================================================
	// declarations
	logic [7:0] ptr_r;
	logic [23:0] dat_r;
	logic [23:0] irq_en_r;
	logic [23:0] irq_clr_r;
	logic [23:0] vrms_lat_r;
	logic [23:0] irms_lat_r;
	logic [23:0] wav1_lat_r;
	logic [23:0] wav2_lat_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic ack_s1_r;
	logic ack_s2_r;
	mra_state_t state_r;
	mra_page_req_t req_r;
	mra_page_req_t req_nxt;
	logic strobe_r;
	logic busy_r;
	logic wr_ptr;
	logic start;
	logic load_rd;

	// ==========================================================
	// bus decode
	assign wr_ptr = SFR_WR && (SFR_ADDR == `MRA_OFS_PTR);
	assign start = wr_ptr && (state_r == MRA_IDLE);
	assign load_rd = (state_r == MRA_REQ) && ack_s2_r && !req_r.write;

	// ==========================================================
	// page acknowledge synchroniser, first stage only feeds second
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end
		else
		begin
			ack_s1_r <= PAGE_ACK;
			ack_s2_r <= ack_s1_r;
		end
	end

	// ==========================================================
	// pointer register, taken only while no transfer runs
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			ptr_r <= `MRA_RST_BYTE;
		else if (start)
			ptr_r <= SFR_WDATA;
	end

	// request word built from pointer and data bytes
	always_comb
	begin
		req_nxt.write = SFR_WDATA[`MRA_PTR_DIR_BIT];
		req_nxt.addr = SFR_WDATA[`MRA_PTR_ADDR_MSB:0];
		if (mra_is_byte_reg(SFR_WDATA[`MRA_PTR_ADDR_MSB:0]))
			req_nxt.data = {16'h0000, dat_r[7:0]};
		else
			req_nxt.data = dat_r;
	end

	// ==========================================================
	// transfer sequencer: four-phase handshake with the page
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			state_r <= MRA_IDLE;
			strobe_r <= 1'b0;
			req_r <= '0;
		end
		else
		begin
			unique case (state_r)
				MRA_IDLE:
				begin
					if (start)
					begin
						req_r <= req_nxt;
						strobe_r <= 1'b1;
						state_r <= MRA_REQ;
					end
				end
				MRA_REQ:
				begin
					if (ack_s2_r)
					begin
						strobe_r <= 1'b0;
						state_r <= MRA_DRAIN;
					end
				end
				MRA_DRAIN:
				begin
					// one strobe per read keeps clear-on-read aliases single
					if (!ack_s2_r)
						state_r <= MRA_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// busy flag: same span as a non-idle sequencer, kept in its own flop
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			busy_r <= 1'b0;
		else if (start)
			busy_r <= 1'b1;
		else if ((state_r == MRA_DRAIN) && !ack_s2_r)
			busy_r <= 1'b0;
	end

	// ==========================================================
	// pointer data bytes: bus writes and page read results
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			dat_r <= `MRA_RST_WORD;
		else if (load_rd)
		begin
			if (mra_is_byte_reg(req_r.addr))
				dat_r <= {16'h0000, PAGE_RDATA[7:0]};
			else
				dat_r <= PAGE_RDATA;
		end
		else if (SFR_WR)
		begin
			if (SFR_ADDR == `MRA_OFS_DAT_LO)
				dat_r[7:0] <= SFR_WDATA;
			if (SFR_ADDR == `MRA_OFS_DAT_MID)
				dat_r[15:8] <= SFR_WDATA;
			if (SFR_ADDR == `MRA_OFS_DAT_HI)
				dat_r[23:16] <= SFR_WDATA;
		end
	end

	// ==========================================================
	// interrupt enable bytes
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			irq_en_r <= `MRA_RST_WORD;
		else if (SFR_WR)
		begin
			if (SFR_ADDR == `MRA_OFS_IEN_LO)
				irq_en_r[7:0] <= SFR_WDATA;
			if (SFR_ADDR == `MRA_OFS_IEN_MID)
				irq_en_r[15:8] <= SFR_WDATA;
			if (SFR_ADDR == `MRA_OFS_IEN_HI)
				irq_en_r[23:16] <= SFR_WDATA;
		end
	end

	// ==========================================================
	// interrupt status bytes: a read latches the live byte into the read data, written ones pulse a clear
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			irq_clr_r <= `MRA_RST_WORD;
		else
		begin
			irq_clr_r <= `MRA_RST_WORD; // clear pulses last one cycle
			if (SFR_WR && (SFR_ADDR == `MRA_OFS_IST_LO))
				irq_clr_r[7:0] <= SFR_WDATA;
			if (SFR_WR && (SFR_ADDR == `MRA_OFS_IST_MID))
				irq_clr_r[15:8] <= SFR_WDATA;
			if (SFR_WR && (SFR_ADDR == `MRA_OFS_IST_HI))
				irq_clr_r[23:16] <= SFR_WDATA;
		end
	end

	// ==========================================================
	// three-byte value capture on high byte read
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			vrms_lat_r <= `MRA_RST_WORD;
			irms_lat_r <= `MRA_RST_WORD;
			wav1_lat_r <= `MRA_RST_WORD;
			wav2_lat_r <= `MRA_RST_WORD;
		end
		else if (SFR_RD)
		begin
			if (SFR_ADDR == `MRA_OFS_VRMS_HI)
				vrms_lat_r <= VRMS_IN;
			if (SFR_ADDR == `MRA_OFS_IRMS_HI)
				irms_lat_r <= IRMS_IN;
			if (SFR_ADDR == `MRA_OFS_WAV1_HI)
				wav1_lat_r <= WAV1_IN;
			if (SFR_ADDR == `MRA_OFS_WAV2_HI)
				wav2_lat_r <= WAV2_IN;
		end
	end

	// ==========================================================
	// read multiplexer; high bytes and status bytes show the value being latched
	always_comb
	begin
		unique case (SFR_ADDR)
			`MRA_OFS_PTR: rdata_nxt = ptr_r;
			`MRA_OFS_DAT_LO: rdata_nxt = dat_r[7:0];
			`MRA_OFS_DAT_MID: rdata_nxt = dat_r[15:8];
			`MRA_OFS_DAT_HI: rdata_nxt = dat_r[23:16];
			`MRA_OFS_VRMS_LO: rdata_nxt = vrms_lat_r[7:0];
			`MRA_OFS_VRMS_MID: rdata_nxt = vrms_lat_r[15:8];
			`MRA_OFS_VRMS_HI: rdata_nxt = VRMS_IN[23:16];
			`MRA_OFS_IRMS_LO: rdata_nxt = irms_lat_r[7:0];
			`MRA_OFS_IRMS_MID: rdata_nxt = irms_lat_r[15:8];
			`MRA_OFS_IRMS_HI: rdata_nxt = IRMS_IN[23:16];
			`MRA_OFS_IEN_LO: rdata_nxt = irq_en_r[7:0];
			`MRA_OFS_IEN_MID: rdata_nxt = irq_en_r[15:8];
			`MRA_OFS_IEN_HI: rdata_nxt = irq_en_r[23:16];
			`MRA_OFS_IST_LO: rdata_nxt = IRQ_STATE_IN[7:0];
			`MRA_OFS_IST_MID: rdata_nxt = IRQ_STATE_IN[15:8];
			`MRA_OFS_IST_HI: rdata_nxt = IRQ_STATE_IN[23:16];
			`MRA_OFS_WAV1_LO: rdata_nxt = wav1_lat_r[7:0];
			`MRA_OFS_WAV1_MID: rdata_nxt = wav1_lat_r[15:8];
			`MRA_OFS_WAV1_HI: rdata_nxt = WAV1_IN[23:16];
			`MRA_OFS_WAV2_LO: rdata_nxt = wav2_lat_r[7:0];
			`MRA_OFS_WAV2_MID: rdata_nxt = wav2_lat_r[15:8];
			`MRA_OFS_WAV2_HI: rdata_nxt = WAV2_IN[23:16];
			default: rdata_nxt = `MRA_RST_BYTE; // unmapped reads as zero
		endcase
	end

	// read data register, updated on each read strobe
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			rdata_r <= `MRA_RST_BYTE;
		else if (SFR_RD)
			rdata_r <= rdata_nxt;
	end

	// ==========================================================
	// outputs, all from flip-flops
	assign SFR_RDATA = rdata_r;
	assign IRQ_ENABLE = irq_en_r;
	assign IRQ_CLEAR = irq_clr_r;
	assign PAGE_REQ = req_r;
	assign PAGE_STROBE = strobe_r;
	assign XFER_BUSY = busy_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	AST_PTR_DIR: assert property (start |=> PAGE_REQ.write == $past(SFR_WDATA[7]) && PAGE_STROBE)
		else $error("pointer direction not carried to the request");
	AST_WR_COPY: assert property (start && !mra_is_byte_reg(SFR_WDATA[6:0]) |=> PAGE_REQ.data == $past(dat_r))
		else $error("wide write did not carry the data bytes");
	AST_WR_NARROW: assert property (start && mra_is_byte_reg(SFR_WDATA[6:0]) |=> PAGE_REQ.data[23:8] == 16'h0000)
		else $error("byte write carried upper data bytes");
	AST_RD_LOAD: assert property (load_rd && !mra_is_byte_reg(req_r.addr) |=> dat_r == $past(PAGE_RDATA))
		else $error("read result not loaded into data bytes");
	AST_RD_NARROW: assert property (load_rd && mra_is_byte_reg(req_r.addr) |=> dat_r[23:8] == 16'h0000)
		else $error("byte read left upper data bytes");
	AST_IRQ_LATCH: assert property (SFR_RD && SFR_ADDR == 8'hDD |=> SFR_RDATA == $past(IRQ_STATE_IN[15:8]))
		else $error("status byte not latched on read");
	AST_HI_CAPTURE: assert property (SFR_RD && SFR_ADDR == 8'hD3 |=> vrms_lat_r == $past(VRMS_IN))
		else $error("high byte read did not capture the value");
	AST_LO_OLD: assert property (SFR_RD && SFR_ADDR == 8'hD1 |=> SFR_RDATA == $past(vrms_lat_r[7:0]))
		else $error("low byte read did not return the old capture");
	AST_DAT_WRITE: assert property (SFR_WR && SFR_ADDR == 8'h93 && !load_rd |=> dat_r[15:8] == $past(SFR_WDATA))
		else $error("middle data byte not written");
	AST_IEN_WRITE: assert property (SFR_WR && SFR_ADDR == 8'hDB |=> IRQ_ENABLE[23:16] == $past(SFR_WDATA))
		else $error("interrupt enable byte not written");
	AST_STROBE_HOLD: assert property (PAGE_STROBE && !ack_s2_r |=> PAGE_STROBE)
		else $error("strobe dropped before acknowledge");
	AST_ONE_STROBE: assert property ($rose(PAGE_STROBE) |-> $past(start))
		else $error("strobe rose without an accepted pointer write");
	AST_DRAIN_QUIET: assert property (state_r == MRA_DRAIN |-> !PAGE_STROBE)
		else $error("strobe high while the handshake drains");
	AST_BUSY_START: assert property (start |=> XFER_BUSY && state_r == MRA_REQ)
		else $error("busy not raised by an accepted pointer write");
	AST_BUSY_DROP: assert property (state_r == MRA_DRAIN && !ack_s2_r |=> !XFER_BUSY)
		else $error("busy not dropped after the handshake returned");
	AST_REFUSE: assert property (wr_ptr && XFER_BUSY |=> ptr_r == $past(ptr_r) && PAGE_REQ == $past(PAGE_REQ))
		else $error("pointer write taken while busy");
	AST_CLR_PULSE: assert property (SFR_WR && SFR_ADDR == 8'hDC |=> IRQ_CLEAR[7:0] == $past(SFR_WDATA))
		else $error("status write did not pulse the clear bits");
	AST_CLR_ONE: assert property (!SFR_WR |=> IRQ_CLEAR == 24'h000000)
		else $error("clear pulse outlived its write");
	AST_UNMAPPED: assert property (SFR_RD && SFR_ADDR == 8'h90 |=> SFR_RDATA == 8'h00)
		else $error("unmapped read not zero");

	COV_WRITE_XFER: cover property (start && SFR_WDATA[7] ##[1:20] $fell(PAGE_STROBE));
	COV_READ_XFER: cover property (load_rd ##[1:20] !XFER_BUSY);
	COV_HI_THEN_LO: cover property ((SFR_RD && SFR_ADDR == 8'hE4) ##[1:5] (SFR_RD && SFR_ADDR == 8'hE2));
	COV_IRQ_CLEAR: cover property (SFR_WR && SFR_ADDR == 8'hDC && SFR_WDATA != 8'h00);
	COV_REFUSED: cover property (wr_ptr && XFER_BUSY);

endmodule : mra_top

// ==== mra_page_model.sv ====
// page-side model of the metering core answering pointer transfers
`timescale 1ns/1ps

module mra_page_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] delay,
	input wire mra_pkg::mra_page_req_t req,
	input wire logic strobe,
	output logic ack,
	output logic [23:0] rdata
);
	import mra_pkg::*;

	// ==========================================================
	// internal page, preset to an address-marked pattern
	logic [23:0] mem [0:127];
	logic [3:0] cnt;

	// each word shows its own address in the low and high bytes
	initial
	begin
		for (int i = 0; i < 128; i++)
			mem[i] = {1'b1, 7'(i), 8'h5A, 1'b0, 7'(i)};
	end

	// ==========================================================
	// four-phase answer after a settable wait; read data is held while strobe and ack
	// are both high or ack rises on a write, loaded when ack rises on a read, and toggles otherwise
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ack <= 1'b0;
			cnt <= 4'h0;
			rdata <= 24'hA5A5A5;
		end
		else if (strobe && !ack && cnt >= delay)
		begin
			ack <= 1'b1;
			cnt <= 4'h0;
			if (req.write)
				mem[req.addr] <= req.data;
			else
				rdata <= mem[req.addr];
			if (!req.write && req.addr == 7'h02)
				mem[req.addr] <= 24'h000000;
		end
		else
		begin
			if (!(strobe && ack))
				rdata <= ~rdata;
			if (strobe && !ack)
				cnt <= cnt + 4'h1;
			if (!strobe && ack)
				ack <= 1'b0;
		end
	end

endmodule : mra_page_model

// ==== mra_top_bench.sv ====
// self-checking bench for the metering register access block
`timescale 1ns/1ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module mra_top_bench;
	import mra_pkg::*;

	// ==========================================================
	// signals
	logic mclk, rst, sfr_wr, sfr_rd, page_strobe, page_ack, xfer_busy;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [23:0] live [0:3];
	logic [23:0] irq_state, irq_enable, irq_clear, page_rdata, v0, v1;
	logic [3:0] delay;
	mra_page_req_t page_req;
	int err_count = 0;
	int check_count = 0;
	int strobes = 0;
	int s0;
	localparam logic [7:0] BASES [0:3] = '{8'hD1, 8'hD4, 8'hE2, 8'hE5};

	mra_top uut
	(
		.MCLK(mclk), .RST(rst), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
		.SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .VRMS_IN(live[0]), .IRMS_IN(live[1]),
		.WAV1_IN(live[2]), .WAV2_IN(live[3]), .IRQ_STATE_IN(irq_state), .IRQ_ENABLE(irq_enable),
		.IRQ_CLEAR(irq_clear), .PAGE_REQ(page_req), .PAGE_STROBE(page_strobe), .PAGE_ACK(page_ack),
		.PAGE_RDATA(page_rdata), .XFER_BUSY(xfer_busy)
	);

	mra_page_model pm
	(
		.clk(mclk), .rst(rst), .delay(delay), .req(page_req), .strobe(page_strobe),
		.ack(page_ack), .rdata(page_rdata)
	);

	// clock and strobe monitor
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge page_strobe) strobes++;

	// ==========================================================
	// bus tasks
	task automatic conclude();
		$display("mismatches %0d of %0d checks", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge mclk);
		sfr_rd = 1'b0;
		@(negedge mclk);
		`CHK(sfr_rdata, e)
	endtask : rd

	// reads low, middle and high byte of a window in that order
	task automatic rd3(input logic [7:0] a, input logic [23:0] e);
		rd(a, e[7:0]);
		rd(a + 8'h01, e[15:8]);
		rd(a + 8'h02, e[23:16]);
	endtask : rd3

	// firmware wait after a transfer, bounded
	task automatic wait_idle();
		int n;
		n = 0;
		@(negedge mclk);
		while (xfer_busy !== 1'b0 && n < 64)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 64)
		begin
			err_count++;
			conclude();
		end
	endtask : wait_idle

	// ==========================================================
	// main sequence
	initial
	begin
		rst = 1'b1;
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 18'h00000;
		live = '{24'h000000, 24'h000000, 24'h000000, 24'h000000};
		irq_state = 24'h000000;
		delay = 4'h0;
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		`CHK(irq_enable, 24'h000000)
		`CHK(xfer_busy, 1'b0)
		// write page word 0x14 and read it back
		wr(8'h92, 8'h55);
		wr(8'h93, 8'h01);
		wr(8'h94, 8'hAA);
		rd3(8'h92, 24'hAA0155);
		wr(8'h91, 8'h94);
		`CHK(page_req, {1'b1, 7'h14, 24'hAA0155})
		wait_idle();
		rd(8'h91, 8'h94);
		rd3(8'h92, 24'hAA0155);
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h14);
		wait_idle();
		rd3(8'h92, 24'hAA0155);
		// one-byte page registers
		wr(8'h91, 8'h8B);
		`CHK(page_req, {1'b1, 7'h0B, 24'h000055})
		wait_idle();
		wr(8'h91, 8'h13);
		wait_idle();
		rd3(8'h92, 24'h000013);
		wr(8'h91, 8'h16);
		wait_idle();
		rd3(8'h92, 24'h965A16);
		// read-with-clear alias: one strobe per read
		wr(8'h92, 8'h56);
		wr(8'h93, 8'h34);
		wr(8'h94, 8'h12);
		wr(8'h91, 8'h82);
		wait_idle();
		s0 = strobes;
		for (int i = 0; i < 2; i++)
		begin
			wr(8'h91, 8'h02);
			wait_idle();
			rd3(8'h92, (i == 0) ? 24'h123456 : 24'h000000);
		end
		`CHK(strobes - s0, 2)
		// pointer write while busy is refused, slow page side
		delay = 4'h8;
		s0 = strobes;
		wr(8'h91, 8'h16);
		wr(8'h91, 8'h8B);
		wait_idle();
		`CHK(strobes - s0, 1)
		rd(8'h91, 8'h16);
		rd3(8'h92, 24'h965A16);
		delay = 4'h0;
		// capture on high byte for rms and waveform windows
		for (int k = 0; k < 4; k++)
		begin
			v0 = {8'hA0 + 8'(k), 8'hB1, 8'hC2};
			v1 = ~v0;
			live[k] = v0;
			rd(BASES[k] + 8'h02, v0[23:16]);
			live[k] = v1;
			wr(BASES[k], 8'hFF);
			rd(BASES[k], v0[7:0]);
			rd(BASES[k] + 8'h01, v0[15:8]);
			rd(BASES[k] + 8'h02, v1[23:16]);
			rd(BASES[k] + 8'h01, v1[15:8]);
		end
		// interrupt enables, status latching and clearing
		wr(8'hD9, 8'h11);
		wr(8'hDA, 8'h22);
		wr(8'hDB, 8'h33);
		`CHK(irq_enable, 24'h332211)
		rd3(8'hD9, 24'h332211);
		irq_state = 24'h00A5C3;
		rd(8'hDC, 8'hC3);
		irq_state = 24'h7E9900;
		rd(8'hDD, 8'h99);
		rd(8'hDE, 8'h7E);
		wr(8'hDC, 8'h03);
		`CHK(irq_clear, 24'h000003)
		@(negedge mclk);
		`CHK(irq_clear, 24'h000000)
		rd(8'h90, 8'h00);
		conclude();
	end

endmodule : mra_top_bench
